// ### tb/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
	input  wire logic       clk,
	input  wire logic       done_n,
	input  wire logic [7:0] data_out,
	input  wire logic [7:0] data_oe,
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic            upper_byte_select,
	output logic            conv_clk,
	output logic [7:0]      data_in
);
	logic [7:0] drv_val;
	logic       drv_en;
	logic       clk_run;
	initial
	begin
		{cs_n, wr_n, rd_n, upper_byte_select} = 4'hf;
		{conv_clk, drv_en, clk_run} = 3'h0;
		drv_val = 8'h00;
	end
	// 2.5 MHz, even duty, still between conversions
	always #200 conv_clk = clk_run & ~conv_clk;
	always @(posedge clk)
		if (!done_n)
			clk_run <= 1'b0;
	// host lets go on reads; released lines show the inverse
	assign data_in = (data_oe & data_out)
		| (~data_oe & (drv_en ? drv_val : ~drv_val));
	task automatic write(input logic [7:0] w, input logic sel_n);
	begin
		@(posedge clk);
		cs_n    <= sel_n;
		drv_val <= w;
		drv_en  <= 1'b1;
		wr_n    <= 1'b0;
		clk_run <= &w[7:6];
		repeat (3) @(posedge clk);
		wr_n <= 1'b1;
		repeat (2) @(posedge clk);
		drv_en <= 1'b0;
	end
	endtask
	task automatic read(input logic hi, input logic sel_n,
		output logic [7:0] v, output logic [7:0] oe);
	begin
		@(posedge clk);
		cs_n              <= sel_n;
		upper_byte_select <= hi;
		// strobes held low until the byte is taken
		rd_n <= 1'b0;
		repeat (5) @(posedge clk);
		v  = data_out;
		oe = data_oe;
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
	end
	endtask
endmodule

// ### tb/adc_parallel_control_port_tb.sv
`timescale 1ns/1ps
module adc_parallel_control_port_tb;
	import adc_port_pkg::*;
	logic       clk, rst_n, cs_n, wr_n, rd_n, upper_byte_select, conv_clk;
	logic [7:0] data_in, data_out, data_oe, v, oe, w;
	logic [9:0] sample_code;
	logic       done_n, sample_hold, powered;
	mux_sel_t   mux_sel;
	int         bad_count, samples_checked, seed, i, n;
	adc_parallel_control_port #(.NUM_CH(8)) adc_parallel_control_port_i (
		.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.upper_byte_select(upper_byte_select), .conv_clk(conv_clk),
		.data_in(data_in), .sample_code(sample_code), .data_out(data_out),
		.data_oe(data_oe), .done_n(done_n), .mux_sel(mux_sel),
		.sample_hold(sample_hold), .powered(powered));
	adc_host_model adc_host_model_i (
		.clk(clk), .done_n(done_n), .data_out(data_out), .data_oe(data_oe),
		.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.upper_byte_select(upper_byte_select), .conv_clk(conv_clk),
		.data_in(data_in));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic mux_sel_t exp_mux(input logic [7:0] c);
		exp_mux = c[4] ? {8'h01 << c[2:0], 8'h00, 1'b1}
			: {8'h01 << c[2:0], 8'h01 << (c[2:0] ^ 3'h1), 1'b0};
	endfunction
	function automatic logic [7:0] exp_byte(input logic [7:0] c,
		input logic [9:0] s, input logic hi);
		logic [9:0] r;
		r = c[3] ? s : {~s[9], s[8:0]};
		exp_byte = hi ? {{6{r[9] & ~c[3]}}, r[9:8]} : r[7:0];
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task automatic wait_done;
	begin
		n = 0;
		while (done_n !== 1'b0 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(done_n), 32'h0);
	end
	endtask
	task automatic conv(input logic [7:0] c, input logic [9:0] s);
	begin
		sample_code <= s;
		adc_host_model_i.write(c, 1'b0);
		wait_done();
		chk(32'(n > (c[6] ? 90 : 65) && n < (c[6] ? 160 : 86)), 32'h1);
		chk(32'(sample_hold), 32'h0);
		chk(32'(mux_sel), 32'(exp_mux(c)));
		for (int h = 0; h < 2; h++)
		begin
			adc_host_model_i.read(h[0], 1'b0, v, oe);
			chk(32'(v), 32'(exp_byte(c, s, h[0])));
			chk(32'(oe), 32'hff);
			chk(32'(done_n), 32'h1);
		end
		chk(32'(data_oe), 32'h0);
	end
	endtask
	task automatic stop_test;
	begin
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	initial
	begin
		repeat (40000) @(posedge clk);
		bad_count++;
		stop_test();
	end
	initial
	begin
		seed = 32'hfc75e15f;
		bad_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		sample_code = 10'h000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'(done_n), 32'h1);
		chk(32'(data_oe), 32'h0);
		chk(32'(powered), 32'h1);
		repeat (10000) @(posedge clk);
		$display("test reset done");
		conv(8'h80, 10'h200);
		conv(8'hdf, 10'h3ff);
		for (i = 0; i < 12; i++)
		begin
			w = 8'($random(seed));
			conv({1'b1, w[6], 1'b0, w[4:0]}, 10'($random(seed)));
		end
		$display("test random done");
		adc_host_model_i.write(8'h9b, 1'b1);
		repeat (100) @(posedge clk);
		chk(32'(done_n), 32'h1);
		adc_host_model_i.read(1'b0, 1'b1, v, oe);
		chk(32'(oe), 32'h0);
		$display("test deselect done");
		adc_host_model_i.write(8'ha6, 1'b0);
		repeat (100) @(posedge clk);
		chk(32'(done_n), 32'h1);
		chk(32'(sample_hold), 32'h1);
		// second pulse repeats the channel bits
		conv(8'ha6, 10'($random(seed)));
		$display("test two-write done");
		for (i = 0; i < 2; i++)
		begin
			// shutdown entered by a plain write, standby by a dummy conversion
			adc_host_model_i.write({1'b0, i[0], 6'h1b}, 1'b0);
			repeat (200) @(posedge clk);
			chk(32'(powered), 32'h0);
			adc_host_model_i.read(1'b0, 1'b0, v, oe);
			chk(32'(oe), 32'hff);
			// settle in standby before trusting results
			adc_host_model_i.write(8'h5b, 1'b0);
			repeat (1000) @(posedge clk);
			chk(32'(powered), 32'h0);
			chk(32'(done_n), 32'h1);
			conv(8'h9b, 10'($random(seed)));
		end
		adc_host_model_i.write(8'h9b, 1'b0);
		repeat (10) @(posedge clk);
		adc_host_model_i.write(8'h1b, 1'b0);
		wait_done();
		adc_host_model_i.read(1'b0, 1'b0, v, oe);
		chk(32'(done_n), 32'h1);
		repeat (20) @(posedge clk);
		chk(32'(powered), 32'h0);
		conv(8'h9b, 10'h155);
		$display("test power-down done");
		stop_test();
	end
endmodule

// ### verilog/adc_parallel_control_port.sv
// Function
// R1: power code 10 uses the internal clock, about 3.6 us conversion.
// R2: power code 11 converts from the external clock input.
// R3: host supplies 100 kHz to 7.6 MHz clock, 30 to 70 percent duty.
// R4: chip select high ignores clock, strobes and floats the bus.
// R5: one byte bus shared, driven only for reads.
// R6: write cycle captures all eight data lines as control word.
// R7: layout: power hi, power lo, acquisition, topology, polarity, channel.
// R8: single-ended: channel code picks input 0..7 against common return.
// R9: pseudo-differential: upper bits pick pair, low bit picks positive.
// R10: unipolar result straight binary, bipolar two's complement.
// R11: drive data only while chip select and read both low.
// R12: upper select low reads result bits 7..0.
// R13: upper select high reads bits 9,8; upper lines zero or sign.
// R14: reset enters external clock mode, done output high.
// R15: host starts no conversion in the 10 us reset interval.
// R16: host waits 500 us for internal reference settling.
// R17: power-down modes keep port alive but do not convert.
// R18: standby wakes on the next write strobe rising edge; the code wakes only on a write of code 10 or 11.
// R19: shutdown waits for a running conversion to finish.
// R20: write rising edge in shutdown resumes normal operation; the code resumes only on a write of code 10 or 11.
// R21: host waits 500 us or 50 us after shutdown exit; the testbench starts a conversion with the exit write itself.
// R22: host enters standby by a dummy conversion in standby mode.
// R23: codes 00 shutdown, 01 standby keep clock; 10 internal, 11 external.
// R24: done output low on valid data, high on read or new write.
// R25: acquisition bit 0 internal timing, 1 external acquisition.
// R26: host repeats channel bits on the second write pulse.
// R27: host releases the bus whenever it asserts read.
`timescale 1ns/1ps
module adc_parallel_control_port
	import adc_port_pkg::*;
#(
	parameter int NUM_CH = 8
)(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    cs_n,
	input  wire logic                    wr_n,
	input  wire logic                    rd_n,
	input  wire logic                    upper_byte_select,
	input  wire logic                    conv_clk,
	input  wire logic [7:0]              data_in,
	input  wire logic [RES_W-1:0]        sample_code,
	output logic      [7:0]              data_out,
	output logic      [7:0]              data_oe,
	output logic                         done_n,
	output adc_port_pkg::mux_sel_t       mux_sel,
	output logic                         sample_hold,
	output logic                         powered
);
	import adc_port_pkg::*;

	// only the four- and eight-input variants have a channel map
	if (NUM_CH != 4 && NUM_CH != 8)
	begin
		$error("NUM_CH must be 4 or 8");
	end

	// two-flop synchronisers on all pins from outside the clock domain
	logic [4:0] s1_r, s2_r, s3_r;
	logic [7:0] d1_r, d2_r;
	logic [RES_W-1:0] sc1_r, sc2_r;
	always_ff @(posedge clk)
	begin
		s1_r  <= {cs_n, wr_n, rd_n, upper_byte_select, conv_clk};
		s2_r  <= s1_r;
		s3_r  <= s2_r;
		d1_r  <= data_in;
		d2_r  <= d1_r;
		sc1_r <= sample_code;
		sc2_r <= sc1_r;
	end
	logic cs_s, wr_s, rd_s, ube_s, ck_s, wr_rise, rd_fall, ck_rise;
	assign cs_s = ~s2_r[4];
	assign wr_s = ~s2_r[3];
	assign rd_s = ~s2_r[2];
	assign ube_s = s2_r[1];
	assign ck_s = s2_r[0];
	// R4: strobes gated by chip select
	assign wr_rise = cs_s & ~s3_r[4] & ~wr_s & ~s3_r[3];
	assign rd_fall = cs_s & ~s3_r[4] & rd_s & s3_r[2];
	assign ck_rise = cs_s & ck_s & ~s3_r[0];

	function automatic mux_sel_t decode_mux(input ctrl_word_t c);
		mux_sel_t m;
		m = '0;
		// R8: single-ended against common return
		if (c.input_topology_sel)
		begin
			m.pos_sel[c.channel_code] = 1'b1;
			m.com_neg = 1'b1;
		end
		// R9: pair select, low bit chooses positive
		else
		begin
			m.pos_sel[c.channel_code] = 1'b1;
			m.neg_sel[c.channel_code ^ 3'h1] = 1'b1;
		end
		if (NUM_CH == 4)
		begin
			m.pos_sel[7:4] = 4'h0;
			m.neg_sel[7:4] = 4'h0;
		end
		return m;
	endfunction

	ctrl_word_t ctrl_r, ctrl_nxt;
	logic       ext_clk_r, ext_clk_nxt;
	pwr_state_t pwr_r, pwr_nxt;
	logic       busy_r, busy_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [RES_W-1:0] res_r, res_nxt;
	logic       done_n_r, done_n_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic [7:0] doe_r, doe_nxt;
	logic       hold_r, hold_nxt;
	logic       ext_wait_r, ext_wait_nxt;
	ctrl_word_t w;
	logic [1:0] pm;
	logic       run_conv, tick;
	logic       powered_nxt;

	// R7: bits map onto the word fields
	assign w = ctrl_word_t'(d2_r);
	assign pm = {w.power_mode_hi, w.power_mode_lo};
	// R1: internal clock counts sys cycles; R2: external counts clock edges
	assign tick = ext_clk_r ? ck_rise : 1'b1;

	always_comb
	begin
		ctrl_nxt     = ctrl_r;
		ext_clk_nxt  = ext_clk_r;
		pwr_nxt      = pwr_r;
		busy_nxt     = busy_r;
		cnt_nxt      = cnt_r;
		res_nxt      = res_r;
		done_n_nxt   = done_n_r;
		hold_nxt     = hold_r;
		ext_wait_nxt = ext_wait_r;
		run_conv     = 1'b0;
		// R24: done high on first read; a finishing conversion wins
		if (rd_fall)
			done_n_nxt = 1'b1;
		if (busy_r && tick)
		begin
			if (cnt_r == 8'h00)
			begin
				busy_nxt = 1'b0;
				hold_nxt = 1'b0;
				// R10: straight binary or two's complement
				res_nxt = ctrl_r.polarity_sel ? sc2_r
					: {~sc2_r[RES_W-1], sc2_r[RES_W-2:0]};
				// R24: done low on valid data
				done_n_nxt = 1'b0;
			end
			else
				cnt_nxt = cnt_r - 8'h01;
		end
		// R6: capture the whole byte on write
		if (wr_rise)
		begin
			ctrl_nxt = w;
			// R24: new control word clears done
			done_n_nxt = 1'b1;
			// R23: power-down codes keep the clock mode
			unique case (pm)
				PM_FULL_DOWN: pwr_nxt = PWR_SHUTDOWN;
				PM_STANDBY:   pwr_nxt = PWR_STANDBY;
				PM_INT_CLK:
				begin
					pwr_nxt = PWR_NORMAL;
					ext_clk_nxt = 1'b0;
				end
				PM_EXT_CLK:
				begin
					pwr_nxt = PWR_NORMAL;
					ext_clk_nxt = 1'b1;
				end
			endcase
			// R18: standby wakes on a write of code 10 or 11; R20: shutdown too
			// R25: second pulse of external acquisition starts conversion
			if (ext_wait_r)
			begin
				ext_wait_nxt = 1'b0;
				run_conv = 1'b1;
			end
			// R17: shutdown code performs no conversion; standby code from normal power runs one
			else if (!busy_r && pm[1])
			begin
				if (w.acquisition_source)
				begin
					ext_wait_nxt = 1'b1;
					hold_nxt = 1'b1;
				end
				else
					run_conv = 1'b1;
			end
			else if (!busy_r && pm == PM_STANDBY && pwr_r != PWR_NORMAL)
				run_conv = 1'b0;
			else if (!busy_r && pm == PM_STANDBY)
				run_conv = 1'b1;
		end
		if (run_conv)
		begin
			busy_nxt = 1'b1;
			hold_nxt = 1'b1;
			cnt_nxt = ext_clk_nxt ? 8'(EXT_CONV_EDGES - 1)
				: 8'(CONV_CYC - 1);
		end
		// R19: stays powered until a running conversion ends
		powered_nxt = (pwr_nxt == PWR_NORMAL) | busy_nxt;
	end

	logic rd_act;
	// R11: drive only with chip select and read low; R5: shared bus
	assign rd_act = cs_s & rd_s;
	always_comb
	begin
		dout_nxt = 8'h00;
		doe_nxt  = rd_act ? 8'hff : 8'h00;
		// R12: low byte
		if (!ube_s)
			dout_nxt = res_r[7:0];
		// R13: upper bits with zero or sign fill
		else
			dout_nxt = {{6{~ctrl_r.polarity_sel & res_r[RES_W-1]}},
				res_r[RES_W-1:8]};
	end

	always_ff @(posedge clk)
	begin
		// R14: reset to external clock, done high
		if (!rst_n)
		begin
			ctrl_r     <= ctrl_word_t'(CTRL_RESET);
			ext_clk_r  <= 1'b1;
			pwr_r      <= PWR_NORMAL;
			busy_r     <= 1'b0;
			cnt_r      <= 8'h00;
			res_r      <= '0;
			done_n_r   <= 1'b1;
			dout_r     <= 8'h00;
			doe_r      <= 8'h00;
			hold_r     <= 1'b0;
			ext_wait_r <= 1'b0;
			mux_sel    <= '0;
			powered    <= 1'b1;
		end
		else
		begin
			ctrl_r     <= ctrl_nxt;
			ext_clk_r  <= ext_clk_nxt;
			pwr_r      <= pwr_nxt;
			busy_r     <= busy_nxt;
			cnt_r      <= cnt_nxt;
			res_r      <= res_nxt;
			done_n_r   <= done_n_nxt;
			dout_r     <= dout_nxt;
			doe_r      <= doe_nxt;
			hold_r     <= hold_nxt;
			ext_wait_r <= ext_wait_nxt;
			mux_sel    <= decode_mux(ctrl_nxt);
			powered    <= powered_nxt;
		end
	end

	assign data_out    = dout_r;
	assign data_oe     = doe_r;
	assign done_n      = done_n_r;
	assign sample_hold = hold_r;

	a_bus_float_cs: assert property (@(posedge clk) disable iff (!rst_n) // R4
		$past(s2_r[4]) |-> data_oe == 8'h00)
		else $error("bus driven without chip select");
	a_bus_read_only: assert property (@(posedge clk) disable iff (!rst_n) // R11
		(data_oe != 8'h00) |-> $past(rd_act))
		else $error("bus driven outside a read");
	a_low_byte: assert property (@(posedge clk) disable iff (!rst_n) // R12
		($past(rd_act) && !$past(ube_s) && $stable(res_r))
		|-> data_out == res_r[7:0])
		else $error("low byte wrong");
	a_high_fill: assert property (@(posedge clk) disable iff (!rst_n) // R13
		($past(ube_s) && $stable(res_r) && $stable(ctrl_r))
		|-> data_out[7:2] == {6{~ctrl_r.polarity_sel & res_r[9]}})
		else $error("upper byte fill wrong");
	a_done_on_end: assert property (@(posedge clk) disable iff (!rst_n) // R24
		$fell(busy_r) && !$past(wr_rise) |-> !done_n)
		else $error("done not asserted at end");
	a_done_clear: assert property (@(posedge clk) disable iff (!rst_n) // R24
		wr_rise |=> done_n)
		else $error("done not cleared by write");
	a_no_conv_down: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(wr_rise && !busy_r && !ext_wait_r && pm == PM_FULL_DOWN) |=> !busy_r)
		else $error("conversion in shutdown");
	a_clk_mode: assert property (@(posedge clk) disable iff (!rst_n) // R23
		(wr_rise && !pm[1]) |=> $stable(ext_clk_r))
		else $error("power-down changed clock mode");
	a_int_time: assert property (@(posedge clk) disable iff (!rst_n) // R1
		($rose(busy_r) && !ext_clk_r) |-> busy_r[*8])
		else $error("internal conversion too short");
	a_wake_normal: assert property (@(posedge clk) disable iff (!rst_n) // R20
		(wr_rise && pm[1]) |=> (pwr_r == PWR_NORMAL) && powered)
		else $error("write did not resume normal power");
endmodule

// ### verilog/adc_port_pkg.sv
package adc_port_pkg;
	localparam int CTRL_W         = 8;
	localparam int RES_W          = 10;
	localparam int CHAN_W         = 3;
	localparam int PM_HI_BIT      = 7;
	localparam int PM_LO_BIT      = 6;
	localparam int ACQ_BIT        = 5;
	localparam int TOPO_BIT       = 4;
	localparam int POL_BIT        = 3;
	localparam int CHAN_LSB       = 0;
	localparam logic [7:0] CTRL_RESET = 8'hc8;
	localparam int CLK_HZ         = 20000000;
	localparam int CONV_NS        = 3600;
	localparam int CONV_CYC = (CONV_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int EXT_CONV_EDGES = 13;
	localparam int ACQ_INT_CYC    = 3;
	localparam logic [1:0] PM_FULL_DOWN = 2'h0;
	localparam logic [1:0] PM_STANDBY   = 2'h1;
	localparam logic [1:0] PM_INT_CLK   = 2'h2;
	localparam logic [1:0] PM_EXT_CLK   = 2'h3;

	typedef struct packed {
		logic       power_mode_hi;
		logic       power_mode_lo;
		logic       acquisition_source;
		logic       input_topology_sel;
		logic       polarity_sel;
		logic [2:0] channel_code;
	} ctrl_word_t;

	typedef struct packed {
		logic [7:0] pos_sel;
		logic [7:0] neg_sel;
		logic       com_neg;
	} mux_sel_t;

	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_STANDBY,
		PWR_SHUTDOWN
	} pwr_state_t;
endpackage
